// ==== shared/fgt_regs.svh ====
// Purpose: offsets, field positions and reset values of the fine gain trim bank
// Assumes: registers are word aligned on the bus, byte address is four times the index
// Notes: definitions only
`ifndef FGT_REGS_SVH
`define FGT_REGS_SVH

// register indices
`define FGT_IDX_A0_DUAL 10'h350
`define FGT_IDX_A1_DUAL 10'h351
`define FGT_IDX_B0_DUAL 10'h352
`define FGT_IDX_B1_DUAL 10'h353
`define FGT_IDX_A0_SINGLE 10'h354
`define FGT_IDX_A1_SINGLE 10'h355
`define FGT_IDX_B0_SINGLE 10'h356
`define FGT_IDX_B1_SINGLE 10'h357
`define FGT_IDX_CTRL 10'h358
`define FGT_IDX_STATUS 10'h359

// slots inside the bank
`define FGT_NUM_TRIM 8
`define FGT_SINGLE_BASE 4
`define FGT_SLOT_CTRL 4'h8
`define FGT_SLOT_STATUS 4'h9
`define FGT_SLOT_MISS 4'hf

// fields
`define FGT_TRIM_MSB 4
`define FGT_TRIM_LSB 0
`define FGT_REG_MSB 7
`define FGT_CTRL_SINGLE_BIT 0
`define FGT_CTRL_RELOAD_BIT 1
`define FGT_STAT_LOADED_BIT 0
`define FGT_STAT_MODE_BIT 1

// reset values
`define FGT_TRIM_RST 8'h00
`define FGT_CTRL_RST 8'h00

// bus
`define FGT_ADDR_W 12
`define FGT_RESP_OKAY 2'b00
`define FGT_RESP_SLVERR 2'b10

`endif

// ==== shared/fgt_pkg.sv ====
// Purpose: types shared by the fine gain trim bank
// Assumes: nothing
// Notes: constants live in fgt_regs.svh
package fgt_pkg;
   typedef logic [7:0] fgt_reg_t;
   typedef logic [4:0] fgt_trim_t;
   typedef logic [3:0] fgt_slot_t;
   typedef enum logic [0:0] {FGT_LOAD, FGT_RUN} fgt_state_t;
endpackage

// ==== hw/fgt_axil_slave.sv ====
// Purpose: axi4-lite slave front end of the fine gain trim bank
// Assumes: one write and one read outstanding at most
// Notes: every bus output comes from a flip-flop
`timescale 1ns/10ps
`include "fgt_regs.svh"
module fgt_axil_slave (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [`FGT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`FGT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wrFire,
   output logic [`FGT_ADDR_W-1:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   input wire logic wrErr,
   output logic rdFire,
   output logic [`FGT_ADDR_W-1:0] rdAddr,
   input wire logic [31:0] rdData,
   input wire logic rdErr
);
   logic awTake, wTake, arTake, bDone, rDone;
   logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, arHeld_q, arHeld_d;

   ////////////////////////////////////////////////////////////////
   // handshakes
   assign awTake = s_axi_awvalid & s_axi_awready;
   assign wTake = s_axi_wvalid & s_axi_wready;
   assign arTake = s_axi_arvalid & s_axi_arready;
   assign bDone = s_axi_bvalid & s_axi_bready;
   assign rDone = s_axi_rvalid & s_axi_rready;
   assign awHeld_d = awTake | (awHeld_q & ~bDone);
   assign wHeld_d = wTake | (wHeld_q & ~bDone);
   assign arHeld_d = arTake | (arHeld_q & ~rDone);
   assign wrFire = awHeld_q & wHeld_q & ~s_axi_bvalid;
   assign rdFire = arHeld_q & ~s_axi_rvalid;

   ////////////////////////////////////////////////////////////////
   // write channels
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         awHeld_q <= awHeld_d;
         wHeld_q <= wHeld_d;
         s_axi_awready <= ~awHeld_d;
         s_axi_wready <= ~wHeld_d;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrAddr <= '0;
         wrData <= '0;
         wrStrb <= '0;
      end else begin
         if (awTake) begin
            wrAddr <= s_axi_awaddr;
         end
         if (wTake) begin
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FGT_RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrErr ? `FGT_RESP_SLVERR : `FGT_RESP_OKAY;
      end else if (bDone) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // read channels
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         arHeld_q <= 1'b0;
         s_axi_arready <= 1'b0;
         rdAddr <= '0;
      end else begin
         arHeld_q <= arHeld_d;
         s_axi_arready <= ~arHeld_d;
         if (arTake) begin
            rdAddr <= s_axi_araddr;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `FGT_RESP_OKAY;
      end else if (rdFire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdData;
         s_axi_rresp <= rdErr ? `FGT_RESP_SLVERR : `FGT_RESP_OKAY;
      end else if (rDone) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ==== hw/fgt_trim_bank.sv ====
// Purpose: fine gain trim register bank for the two converter cores
// Assumes: fuse values are stable whenever the bank loads them
// Notes: trims applied to the cores follow the selected channel mode
//
// Behaviour
// - read-write register, 5-bit trim core A bank 0 dual mode, bits 4:0.
// - read-write register, 5-bit trim core A bank 1 dual mode.
// - read-write register, 5-bit trim core B bank 0 dual mode.
// - read-write register, 5-bit trim core B bank 1 dual mode.
// - separate read-write register, trim core A bank 0 single mode.
// - separate read-write register, trim core A bank 1 single mode.
// - separate read-write register, trim core B bank 0 single mode.
// - separate read-write register, trim core B bank 1 single mode.
// - after reset every trim field loads its factory fuse value.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "fgt_regs.svh"
module fgt_trim_bank (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [`FGT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`FGT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire fgt_pkg::fgt_trim_t fuseA0Dual,
   input wire fgt_pkg::fgt_trim_t fuseA1Dual,
   input wire fgt_pkg::fgt_trim_t fuseB0Dual,
   input wire fgt_pkg::fgt_trim_t fuseB1Dual,
   input wire fgt_pkg::fgt_trim_t fuseA0Single,
   input wire fgt_pkg::fgt_trim_t fuseA1Single,
   input wire fgt_pkg::fgt_trim_t fuseB0Single,
   input wire fgt_pkg::fgt_trim_t fuseB1Single,
   output fgt_pkg::fgt_trim_t trimA0,
   output fgt_pkg::fgt_trim_t trimA1,
   output fgt_pkg::fgt_trim_t trimB0,
   output fgt_pkg::fgt_trim_t trimB1,
   output logic singleMode
);
   fgt_pkg::fgt_state_t state_q;
   fgt_pkg::fgt_reg_t trim_q [`FGT_NUM_TRIM];
   fgt_pkg::fgt_trim_t fuseVec [`FGT_NUM_TRIM];
   fgt_pkg::fgt_reg_t ctrl_q;
   logic loaded_q;
   logic wrFire, rdFire, wrErr, rdErr;
   logic [`FGT_ADDR_W-1:0] wrAddr, rdAddr;
   logic [31:0] wrData, rdData;
   logic [3:0] wrStrb;
   fgt_pkg::fgt_slot_t wrSlot, rdSlot;
   logic wrLane0, reloadReq, ctrlHit;
   logic [`FGT_NUM_TRIM-1:0] trimHit;

   ////////////////////////////////////////////////////////////////
   // helpers
   function automatic fgt_pkg::fgt_slot_t slotOf(input logic [`FGT_ADDR_W-1:0] addr);
      logic [9:0] idx;
      fgt_pkg::fgt_slot_t slot;
      idx = addr[`FGT_ADDR_W-1:2];
      case (idx)
         `FGT_IDX_A0_DUAL: begin
            slot = 4'h0;
         end
         `FGT_IDX_A1_DUAL: begin
            slot = 4'h1;
         end
         `FGT_IDX_B0_DUAL: begin
            slot = 4'h2;
         end
         `FGT_IDX_B1_DUAL: begin
            slot = 4'h3;
         end
         `FGT_IDX_A0_SINGLE: begin
            slot = 4'h4;
         end
         `FGT_IDX_A1_SINGLE: begin
            slot = 4'h5;
         end
         `FGT_IDX_B0_SINGLE: begin
            slot = 4'h6;
         end
         `FGT_IDX_B1_SINGLE: begin
            slot = 4'h7;
         end
         `FGT_IDX_CTRL: begin
            slot = `FGT_SLOT_CTRL;
         end
         `FGT_IDX_STATUS: begin
            slot = `FGT_SLOT_STATUS;
         end
         default: begin
            slot = `FGT_SLOT_MISS;
         end
      endcase
      if (addr[1:0] != 2'b00) begin
         slot = `FGT_SLOT_MISS;
      end
      return slot;
   endfunction

   function automatic fgt_pkg::fgt_trim_t fieldOf(input fgt_pkg::fgt_reg_t value);
      return value[`FGT_TRIM_MSB:`FGT_TRIM_LSB];
   endfunction

   ////////////////////////////////////////////////////////////////
   // bus front end
   fgt_axil_slave u_slave (
      .clk_sys(clk_sys),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wrFire(wrFire),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrErr(wrErr),
      .rdFire(rdFire),
      .rdAddr(rdAddr),
      .rdData(rdData),
      .rdErr(rdErr)
   );

   ////////////////////////////////////////////////////////////////
   // address decode
   assign wrSlot = slotOf(wrAddr);
   assign rdSlot = slotOf(rdAddr);
   assign wrErr = (wrSlot == `FGT_SLOT_MISS);
   assign rdErr = (rdSlot == `FGT_SLOT_MISS);
   assign wrLane0 = wrFire & wrStrb[0];
   assign ctrlHit = wrLane0 & (wrSlot == `FGT_SLOT_CTRL);
   assign reloadReq = ctrlHit & wrData[`FGT_CTRL_RELOAD_BIT];

   ////////////////////////////////////////////////////////////////
   // write hits per trim slot
   always_comb begin
      for (int i = 0; i < `FGT_NUM_TRIM; i++) begin
         trimHit[i] = wrLane0 && (wrSlot == fgt_pkg::fgt_slot_t'(i));
      end
   end

   ////////////////////////////////////////////////////////////////
   // fuse values in slot order
   assign fuseVec[0] = fuseA0Dual;
   assign fuseVec[1] = fuseA1Dual;
   assign fuseVec[2] = fuseB0Dual;
   assign fuseVec[3] = fuseB1Dual;
   assign fuseVec[4] = fuseA0Single;
   assign fuseVec[5] = fuseA1Single;
   assign fuseVec[6] = fuseB0Single;
   assign fuseVec[7] = fuseB1Single;

   ////////////////////////////////////////////////////////////////
   // load sequencer
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= fgt_pkg::FGT_LOAD;
      end else begin
         case (state_q)
            fgt_pkg::FGT_LOAD: begin
               state_q <= fgt_pkg::FGT_RUN;
            end
            fgt_pkg::FGT_RUN: begin
               if (reloadReq) begin
                  state_q <= fgt_pkg::FGT_LOAD;
               end
            end
            default: begin
               state_q <= fgt_pkg::FGT_LOAD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         loaded_q <= 1'b0;
      end else if (state_q == fgt_pkg::FGT_LOAD) begin
         loaded_q <= 1'b1;
      end else if (reloadReq) begin
         loaded_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // trim registers, fuse load beats a write in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `FGT_NUM_TRIM; i++) begin
            trim_q[i] <= `FGT_TRIM_RST;
         end
      end else begin
         for (int i = 0; i < `FGT_NUM_TRIM; i++) begin
            if (state_q == fgt_pkg::FGT_LOAD) begin
               trim_q[i] <= {3'b000, fuseVec[i]};
            end else if (trimHit[i]) begin
               trim_q[i] <= wrData[`FGT_REG_MSB:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // control register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_q <= `FGT_CTRL_RST;
      end else if (ctrlHit) begin
         ctrl_q <= wrData[`FGT_REG_MSB:0];
         ctrl_q[`FGT_CTRL_RELOAD_BIT] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rdData = '0;
      case (rdSlot)
         4'h0, 4'h1, 4'h2, 4'h3: begin
            rdData[`FGT_REG_MSB:0] = trim_q[rdSlot[2:0]];
         end
         4'h4, 4'h5, 4'h6, 4'h7: begin
            rdData[`FGT_REG_MSB:0] = trim_q[rdSlot[2:0]];
         end
         `FGT_SLOT_CTRL: begin
            rdData[`FGT_REG_MSB:0] = ctrl_q;
         end
         `FGT_SLOT_STATUS: begin
            rdData[`FGT_STAT_LOADED_BIT] = loaded_q;
            rdData[`FGT_STAT_MODE_BIT] = singleMode;
         end
         default: begin
            rdData = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // applied trims per core and bank
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         singleMode <= 1'b0;
      end else begin
         singleMode <= ctrl_q[`FGT_CTRL_SINGLE_BIT];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trimA0 <= '0;
      end else if (ctrl_q[`FGT_CTRL_SINGLE_BIT]) begin
         trimA0 <= fieldOf(trim_q[`FGT_SINGLE_BASE]);
      end else begin
         trimA0 <= fieldOf(trim_q[0]);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trimA1 <= '0;
      end else if (ctrl_q[`FGT_CTRL_SINGLE_BIT]) begin
         trimA1 <= fieldOf(trim_q[`FGT_SINGLE_BASE + 1]);
      end else begin
         trimA1 <= fieldOf(trim_q[1]);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trimB0 <= '0;
      end else if (ctrl_q[`FGT_CTRL_SINGLE_BIT]) begin
         trimB0 <= fieldOf(trim_q[`FGT_SINGLE_BASE + 2]);
      end else begin
         trimB0 <= fieldOf(trim_q[2]);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         trimB1 <= '0;
      end else if (ctrl_q[`FGT_CTRL_SINGLE_BIT]) begin
         trimB1 <= fieldOf(trim_q[`FGT_SINGLE_BASE + 3]);
      end else begin
         trimB1 <= fieldOf(trim_q[3]);
      end
   end
endmodule

// ==== test/fgt_trim_bank_assertions.sv ====
// Purpose: bus timing and trim output checks for the trim bank
// Assumes: only top level ports are visible
// Notes: bound to every fgt_trim_bank instance
`timescale 1ns/10ps
`include "fgt_regs.svh"
module fgt_trim_bank_assertions (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`FGT_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire fgt_pkg::fgt_trim_t fuseA0Dual,
   input wire fgt_pkg::fgt_trim_t trimA0,
   input wire logic singleMode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic awHs;
   logic wHs;
   logic arHs;
   logic badRd;
   assign awHs = s_axi_awvalid & s_axi_awready;
   assign wHs = s_axi_wvalid & s_axi_wready;
   assign arHs = s_axi_arvalid & s_axi_arready;
   assign badRd = (s_axi_araddr[1:0] != 2'b00) || (s_axi_araddr < 12'hd40) || (s_axi_araddr > 12'hd64);
   ////////////////////////////////////////////////////////////////
   a_wr_resp_delay: assert property (awHs && wHs |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_rd_resp_delay: assert property (arHs |-> ##2 s_axi_rvalid)
      else $error("read data late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_rdata_byte_only: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_bad_read_err: assert property (arHs && badRd |-> ##2 (s_axi_rvalid && s_axi_rdata == 32'h0
      && s_axi_rresp == `FGT_RESP_SLVERR))
      else $error("unmapped read not refused");
   a_aw_block: assert property (awHs |=> !s_axi_awready [*2])
      else $error("write address taken twice");
   a_ar_block: assert property (arHs |=> !s_axi_arready [*2])
      else $error("read address taken twice");
   a_fuse_load: assert property ($fell(rst) |-> ##2 (trimA0 == fuseA0Dual && !singleMode))
      else $error("fuse value not applied");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_bad_read: cover property (arHs && badRd);
   c_single: cover property ($rose(singleMode));
endmodule
////////////////////////////////////////////////////////////////
bind fgt_trim_bank fgt_trim_bank_assertions i_chk (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .fuseA0Dual, .trimA0, .singleMode);

// ==== test/fgt_trim_bank_tb.sv ====
// Purpose: self-checking bench for the trim bank
// Assumes: byte address is four times the register index
// Notes: one verdict line at the end
`timescale 1ns/10ps
`include "fgt_regs.svh"
module fgt_trim_bank_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h0;
   logic [11:0] s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic [3:0] strb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, singleMode;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   fgt_pkg::fgt_trim_t trimA0, trimA1, trimB0, trimB1;
   fgt_pkg::fgt_trim_t fuse [8] = '{5'h03, 5'h0c, 5'h15, 5'h1e, 5'h07, 5'h18, 5'h0a, 5'h1f};
   fgt_pkg::fgt_reg_t expReg [8];
   int miscompares = 0;
   int cmp_count = 0;
   int cyc = 0;
   fgt_trim_bank i_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .fuseA0Dual(fuse[0]), .fuseA1Dual(fuse[1]), .fuseB0Dual(fuse[2]),
      .fuseB1Dual(fuse[3]), .fuseA0Single(fuse[4]), .fuseA1Single(fuse[5]), .fuseB0Single(fuse[6]),
      .fuseB1Single(fuse[7]), .trimA0, .trimA1, .trimB0, .trimB1, .singleMode);
   always #2.5 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 2000) begin
         miscompares++;
         $display("mismatch at %0t: timeout", $time);
         end_sim();
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   function automatic logic [11:0] ad(input int i);
      return {`FGT_IDX_A0_DUAL, 2'b00} + 12'(4 * i);
   endfunction
   ////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aHs, wHs, done;
      done = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(negedge clk_sys);
         aHs = s_axi_awvalid & s_axi_awready;
         wHs = s_axi_wvalid & s_axi_wready;
         done = s_axi_bvalid & s_axi_bready;
         if (done) cmp({30'h0, s_axi_bresp}, {30'h0, er}, "write resp");
         @(posedge clk_sys);
         if (aHs) s_axi_awvalid <= 1'b0;
         if (wHs) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic aHs, done;
      done = 1'b0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(negedge clk_sys);
         aHs = s_axi_arvalid & s_axi_arready;
         done = s_axi_rvalid & s_axi_rready;
         if (done) cmp(s_axi_rdata, ed, "read data");
         if (done) cmp({30'h0, s_axi_rresp}, {30'h0, er}, "read resp");
         @(posedge clk_sys);
         if (aHs) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask
   task automatic chkTrims(input int b, input logic m);
      repeat (2) @(negedge clk_sys);
      cmp({31'h0, singleMode}, {31'h0, m}, "mode");
      cmp({27'h0, trimA0}, {27'h0, expReg[b][4:0]}, "trim a0");
      cmp({27'h0, trimA1}, {27'h0, expReg[b+1][4:0]}, "trim a1");
      cmp({27'h0, trimB0}, {27'h0, expReg[b+2][4:0]}, "trim b0");
      cmp({27'h0, trimB1}, {27'h0, expReg[b+3][4:0]}, "trim b1");
      @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         expReg[i] = {3'b000, fuse[i]};
         rdChk(ad(i), {24'h0, expReg[i]}, `FGT_RESP_OKAY);
      end
      chkTrims(0, 1'b0);
      rdChk({`FGT_IDX_STATUS, 2'b00}, 32'h1, `FGT_RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         expReg[i] = 8'ha5 + 8'(19 * i);
         wr(ad(i), expReg[i], `FGT_RESP_OKAY);
      end
      for (int i = 0; i < 8; i++) begin
         rdChk(ad(i), {24'h0, expReg[i]}, `FGT_RESP_OKAY);
      end
      chkTrims(0, 1'b0);
      strb = 4'he;
      wr(ad(1), 8'h00, `FGT_RESP_OKAY);
      strb = 4'h1;
      rdChk(ad(1), {24'h0, expReg[1]}, `FGT_RESP_OKAY);
      wr({`FGT_IDX_CTRL, 2'b00}, 8'h01, `FGT_RESP_OKAY);
      chkTrims(4, 1'b1);
      rdChk({`FGT_IDX_CTRL, 2'b00}, 32'h1, `FGT_RESP_OKAY);
      rdChk({`FGT_IDX_STATUS, 2'b00}, 32'h3, `FGT_RESP_OKAY);
      wr(12'hd42, 8'hff, `FGT_RESP_SLVERR);
      rdChk(12'hd68, 32'h0, `FGT_RESP_SLVERR);
      rdChk(ad(0), {24'h0, expReg[0]}, `FGT_RESP_OKAY);
      wr({`FGT_IDX_CTRL, 2'b00}, 8'h03, `FGT_RESP_OKAY);
      repeat (3) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         expReg[i] = {3'b000, fuse[i]};
         rdChk(ad(i), {24'h0, expReg[i]}, `FGT_RESP_OKAY);
      end
      chkTrims(4, 1'b1);
      rdChk({`FGT_IDX_CTRL, 2'b00}, 32'h1, `FGT_RESP_OKAY);
      wr(ad(0), 8'h1b, `FGT_RESP_OKAY);
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      rdChk(ad(0), {24'h0, expReg[0]}, `FGT_RESP_OKAY);
      chkTrims(0, 1'b0);
      end_sim();
   end
endmodule
